// [verilog/usart_rx_params.svh]
`ifndef USART_RX_PARAMS_SVH
`define USART_RX_PARAMS_SVH
// Register word indices (printed offsets not all multiples of four: index * 4)
`define IDX_IRQ_FLAGS     8'h0C
`define IDX_RX_STATUS     8'h18
`define IDX_TX_DATA       8'h19
`define IDX_RX_DATA       8'h1A
`define IDX_IRQ_ENABLES   8'h8C
`define IDX_TX_STATUS     8'h98
`define IDX_BAUD_DIV      8'h99
`define IDX_SLEEP_CTRL    8'hA0
`define IDX_CPU_CTRL      8'hA1
// Field positions
`define RCV_IRQ_BIT       5
`define PORT_EN_BIT       7
`define NINE_BIT_BIT      6
`define SINGLE_RX_BIT     5
`define CONT_RX_BIT       4
`define FRAME_ERR_BIT     2
`define OVERRUN_BIT       1
`define NINTH_DATA_BIT    0
`define CLK_SRC_BIT       7
`define SYNC_MODE_BIT     4
`define HS_BAUD_BIT       2
// Reset values
`define TX_STATUS_RESET   8'h02
`define IRQ_VECTOR        16'h0004
`define BAUD_DIV_MAX      8'hFF
`endif

// [verilog/usart_rx_pkg.sv]
package usart_rx_pkg;
   typedef struct packed {
      logic [31:0] addr;
      logic        valid;
   } addr_beat_t;
   typedef struct packed {
      logic [8:0] data;
      logic       overrun;
   } rx_word_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} rx_state_t;
endpackage

// [verilog/rx_hold_mem.sv]
`timescale 1ns/1ns
// Small holding register for received words; read data registered
module rx_hold_mem #(
   parameter int WIDTH = 9
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset,
   // Write side
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   // Read side
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_q;
   logic [WIDTH-1:0] mem_d;
   logic [WIDTH-1:0] rd_q;

   // Next value of the stored word
   always_comb begin
      mem_d = wr_en ? wr_data : mem_q;
   end

   // Store and register the read port
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mem_q <= '0;
         rd_q  <= '0;
      end else begin
         mem_q <= mem_d;
         rd_q  <= mem_d;
      end
   end

   assign rd_data = rd_q;
endmodule

// [verilog/usart_sync_slave_receive.sv]
`timescale 1ns/1ns
`include "usart_rx_params.svh"
module usart_sync_slave_receive
   import usart_rx_pkg::*;
#(
   parameter int DATA_BITS = 9
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // AXI4-Lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Serial link from the external master
   input  wire logic        link_clk,
   input  wire logic        link_data,
   // Chip-level outputs
   output logic             irq,
   output logic             wake,
   output logic             vector_branch,
   output logic [15:0]      vector_addr,
   output logic             baud_tick
);
   import usart_rx_pkg::*;

   // Word index from a byte address; unmapped when low bits set
   function automatic logic [7:0] reg_index(input logic [31:0] a);
      reg_index = a[9:2];
   endfunction

   // Link synchronisers: first stage read only by second
   logic [1:0] clk_sync_q;
   logic [1:0] dat_sync_q;
   logic       clk_prev_q;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         clk_sync_q <= 2'h0;
         dat_sync_q <= 2'h0;
         clk_prev_q <= 1'b0;
      end else begin
         clk_sync_q <= {clk_sync_q[0], link_clk};
         dat_sync_q <= {dat_sync_q[0], link_data};
         clk_prev_q <= clk_sync_q[1];
      end
   end
   // Data is sampled on the falling edge of the master clock
   logic link_fall;
   assign link_fall = clk_prev_q & ~clk_sync_q[1];

   // Register state
   logic [7:0] rx_ctrl_q, rx_ctrl_d;
   logic [7:0] tx_ctrl_q, tx_ctrl_d;
   logic [7:0] baud_q, baud_d;
   logic [7:0] ien_q, ien_d;
   logic       rcv_flag_q, rcv_flag_d;
   logic       overrun_q, overrun_d;
   logic       ninth_q, ninth_d;
   logic       sleep_q, sleep_d;
   logic       gie_q, gie_d;

   // Receiver state
   rx_state_t  st_q, st_d;
   logic [8:0] shreg_q, shreg_d;
   logic [3:0] bitcnt_q, bitcnt_d;
   logic       xfer;
   logic [8:0] hold_rd;

   logic port_on, cont_rx, nine_on, slave_sync;
   assign port_on    = rx_ctrl_q[`PORT_EN_BIT];
   assign cont_rx    = rx_ctrl_q[`CONT_RX_BIT];
   assign nine_on    = rx_ctrl_q[`NINE_BIT_BIT];
   // Single-receive bit is not consulted at all in slave mode
   assign slave_sync = port_on & tx_ctrl_q[`SYNC_MODE_BIT] & ~tx_ctrl_q[`CLK_SRC_BIT];

   // Bus handshake state
   logic       aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
   logic [7:0] awidx_q, awidx_d;
   logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d;
   logic       wbad_q, wbad_d, rbad_q, rbad_d;
   logic       do_write, do_read;
   logic [7:0] ridx;

   assign s_axi_awready = ~aw_q & ~b_q;
   assign s_axi_wready  = ~w_q & ~b_q;
   assign s_axi_arready = ~r_q;
   assign do_write      = aw_q & w_q & ~b_q;
   assign ridx          = reg_index(s_axi_araddr);
   assign do_read       = s_axi_arvalid & ~r_q;

   // Write side of the bus slave
   always_comb begin
      aw_d    = aw_q;
      w_d     = w_q;
      b_d     = b_q;
      awidx_d = awidx_q;
      wdat_d  = wdat_q;
      wbad_d  = wbad_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d    = 1'b1;
         awidx_d = reg_index(s_axi_awaddr);
         wbad_d  = |s_axi_awaddr[1:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d    = 1'b1;
         wdat_d = s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end
      if (do_write) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         b_d  = 1'b1;
      end
      if (b_q && s_axi_bready) begin
         b_d = 1'b0;
      end
   end

   // Register writes and hardware updates
   always_comb begin
      rx_ctrl_d  = rx_ctrl_q;
      tx_ctrl_d  = tx_ctrl_q;
      baud_d     = baud_q;
      ien_d      = ien_q;
      rcv_flag_d = rcv_flag_q;
      overrun_d  = overrun_q;
      ninth_d    = ninth_q;
      sleep_d    = sleep_q;
      gie_d      = gie_q;
      if (do_write && !wbad_q) begin
         case (awidx_q)
            `IDX_RX_STATUS:   rx_ctrl_d = {wdat_q[7:4], 4'h0};
            `IDX_TX_STATUS:   tx_ctrl_d = {wdat_q[7:3], wdat_q[2], tx_ctrl_q[1], 1'b0};
            `IDX_BAUD_DIV:    baud_d = wdat_q[7:0];
            `IDX_IRQ_ENABLES: ien_d = wdat_q[7:0];
            `IDX_IRQ_FLAGS: begin
               if (wdat_q[`RCV_IRQ_BIT]) begin
                  rcv_flag_d = 1'b0;
               end
            end
            `IDX_SLEEP_CTRL:  sleep_d = wdat_q[0];
            `IDX_CPU_CTRL:    gie_d = wdat_q[0];
            default: ;
         endcase
      end
      // Reading the data buffer also drains the flag
      if (do_read && ridx == `IDX_RX_DATA && !(|s_axi_araddr[1:0])) begin
         rcv_flag_d = 1'b0;
      end
      // Dropping continuous receive clears the error
      if (!rx_ctrl_d[`CONT_RX_BIT]) begin
         overrun_d = 1'b0;
      end
      // Completion wins over a same-cycle clear
      if (xfer) begin
         rcv_flag_d = 1'b1;
         ninth_d    = nine_on ? shreg_d[8] : 1'b0;
         // A word that lands as receive is dropped must not leave a stale error
         if (rcv_flag_q && rx_ctrl_d[`CONT_RX_BIT]) begin
            overrun_d = 1'b1;
         end
      end
      // Interrupt wakes the chip
      if (irq) begin
         sleep_d = 1'b0;
      end
   end

   // Shift engine, same in sleep as awake when continuous receive is on
   always_comb begin
      st_d     = st_q;
      shreg_d  = shreg_q;
      bitcnt_d = bitcnt_q;
      xfer     = 1'b0;
      case (st_q)
         ST_IDLE: begin
            bitcnt_d = 4'h0;
            if (slave_sync && cont_rx && !overrun_q) begin
               st_d = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (!slave_sync || !cont_rx) begin
               st_d = ST_IDLE;
            end else if (link_fall) begin
               // LSB first, one bit per falling master edge
               shreg_d  = {dat_sync_q[1], shreg_q[8:1]};
               bitcnt_d = bitcnt_q + 4'h1;
               if (bitcnt_q == (nine_on ? 4'h8 : 4'h7)) begin
                  st_d = ST_DONE;
                  if (!nine_on) begin
                     shreg_d = {1'b0, dat_sync_q[1], shreg_q[8:2]};
                  end
               end
            end
         end
         ST_DONE: begin
            xfer = 1'b1;
            st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // Received words land in the buffer register
   rx_hold_mem #(.WIDTH(9)) u_hold (
      .core_clk (core_clk),
      .reset    (reset),
      .wr_en    (xfer),
      .wr_data  (shreg_q),
      .rd_data  (hold_rd)
   );

   // Read side of the bus slave
   logic [7:0] flags_rd, status_rd;
   assign flags_rd  = {2'h0, rcv_flag_q, 5'h00};
   assign status_rd = {rx_ctrl_q[7:4], 1'b0, 1'b0, overrun_q, ninth_q};
   always_comb begin
      r_d    = r_q;
      rdat_d = rdat_q;
      rbad_d = rbad_q;
      if (do_read) begin
         r_d    = 1'b1;
         rbad_d = |s_axi_araddr[1:0];
         case (ridx)
            `IDX_IRQ_FLAGS:   rdat_d = {24'h000000, flags_rd};
            `IDX_RX_STATUS:   rdat_d = {24'h000000, status_rd};
            `IDX_TX_DATA:     rdat_d = 32'h0000_0000;
            `IDX_RX_DATA:     rdat_d = {24'h000000, hold_rd[7:0]};
            `IDX_IRQ_ENABLES: rdat_d = {24'h000000, ien_q};
            `IDX_TX_STATUS:   rdat_d = {24'h000000, tx_ctrl_q};
            `IDX_BAUD_DIV:    rdat_d = {24'h000000, baud_q};
            `IDX_SLEEP_CTRL:  rdat_d = {31'h0, sleep_q};
            `IDX_CPU_CTRL:    rdat_d = {31'h0, gie_q};
            default: begin
               rdat_d = 32'h0000_0000;
               rbad_d = 1'b1;
            end
         endcase
      end else if (r_q && s_axi_rready) begin
         r_d = 1'b0;
      end
   end

   // Baud divider: 255 slowest, 0 fastest; /4 when high speed
   logic [7:0] bdiv_q, bdiv_d;
   logic [3:0] pre_q, pre_d;
   always_comb begin
      pre_d     = pre_q + 4'h1;
      bdiv_d    = bdiv_q;
      baud_tick = 1'b0;
      if (pre_q == (tx_ctrl_q[`HS_BAUD_BIT] ? 4'h3 : 4'hF)) begin
         pre_d = 4'h0;
         if (bdiv_q == 8'h00) begin
            bdiv_d    = baud_q;
            baud_tick = 1'b1;
         end else begin
            bdiv_d = bdiv_q - 8'h01;
         end
      end
   end

   // Registers of every group except the link synchronisers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rx_ctrl_q  <= 8'h00;
         tx_ctrl_q  <= `TX_STATUS_RESET;
         baud_q     <= 8'h00;
         ien_q      <= 8'h00;
         rcv_flag_q <= 1'b0;
         overrun_q  <= 1'b0;
         ninth_q    <= 1'b0;
         sleep_q    <= 1'b0;
         gie_q      <= 1'b0;
         st_q       <= ST_IDLE;
         shreg_q    <= 9'h000;
         bitcnt_q   <= 4'h0;
         aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
         awidx_q    <= 8'h00;
         wdat_q     <= 32'h0000_0000;
         rdat_q     <= 32'h0000_0000;
         wbad_q     <= 1'b0;
         rbad_q     <= 1'b0;
         bdiv_q     <= 8'h00;
         pre_q      <= 4'h0;
      end else begin
         rx_ctrl_q  <= rx_ctrl_d;
         tx_ctrl_q  <= tx_ctrl_d;
         baud_q     <= baud_d;
         ien_q      <= ien_d;
         rcv_flag_q <= rcv_flag_d;
         overrun_q  <= overrun_d;
         ninth_q    <= ninth_d;
         sleep_q    <= sleep_d;
         gie_q      <= gie_d;
         st_q       <= st_d;
         shreg_q    <= shreg_d;
         bitcnt_q   <= bitcnt_d;
         aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
         awidx_q    <= awidx_d;
         wdat_q     <= wdat_d;
         rdat_q     <= rdat_d;
         wbad_q     <= wbad_d;
         rbad_q     <= rbad_d;
         bdiv_q     <= bdiv_d;
         pre_q      <= pre_d;
      end
   end

   // Outputs
   assign s_axi_bvalid  = b_q;
   assign s_axi_bresp   = wbad_q ? 2'b10 : 2'b00;
   assign s_axi_rvalid  = r_q;
   assign s_axi_rdata   = rdat_q;
   assign s_axi_rresp   = rbad_q ? 2'b10 : 2'b00;
   assign irq           = rcv_flag_q & ien_q[`RCV_IRQ_BIT];
   assign wake          = irq & sleep_q;
   assign vector_branch = irq & gie_q;
   assign vector_addr   = `IRQ_VECTOR;

   // Assertions
   a_flag_on_done: assert property (@(posedge core_clk) disable iff (reset)
      xfer |=> rcv_flag_q) else $error("flag not set after word");
   a_irq_gated: assert property (@(posedge core_clk) disable iff (reset)
      irq |-> (rcv_flag_q && ien_q[`RCV_IRQ_BIT])) else $error("irq without cause");
   a_wake_sleep: assert property (@(posedge core_clk) disable iff (reset)
      (irq && sleep_q) |=> !sleep_q) else $error("no wake");
   a_vector_gie: assert property (@(posedge core_clk) disable iff (reset)
      vector_branch |-> (gie_q && vector_addr == 16'h0004)) else $error("bad vector");
   a_err_clear: assert property (@(posedge core_clk) disable iff (reset)
      !cont_rx |-> !overrun_q) else $error("error kept");
   a_buf_load: assert property (@(posedge core_clk) disable iff (reset)
      xfer |=> ##1 (hold_rd == $past(shreg_q, 2))) else $error("buffer not loaded");
   a_idle_off: assert property (@(posedge core_clk) disable iff (reset)
      (!slave_sync && st_q == ST_SHIFT) |=> st_q == ST_IDLE) else $error("shift off");
   a_shift_edge: assert property (@(posedge core_clk) disable iff (reset)
      (st_q == ST_SHIFT && slave_sync && cont_rx && !link_fall) |=> $stable(bitcnt_q))
      else $error("shift without edge");
   a_ninth_off: assert property (@(posedge core_clk) disable iff (reset)
      (xfer && !nine_on) |=> !ninth_q) else $error("ninth bit set");
endmodule

// [verif/link_master.sv]
`timescale 1ns/1ns
// External synchronous master: makes the shift clock and drives data, LSB first
module link_master #(
   parameter int HALF_NS = 400
) (
   // Serial link
   output logic link_clk,
   output logic link_data
);
   // Clock parks high between words so no stray falling edge reaches the receiver
   initial begin
      link_clk  = 1'b1;
      link_data = 1'b1;
   end

   // One falling edge per data bit, data set while the clock is high
   task automatic send_word(input logic [8:0] w, input int nbits);
      for (int i = 0; i < nbits; i++) begin
         link_data = w[i];
         #HALF_NS link_clk = 1'b0;
         #HALF_NS link_clk = 1'b1;
      end
      // Released line shows the inverse, so stale data never passes for a bit
      link_data = ~w[nbits-1];
   endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ns
`include "usart_rx_params.svh"
module testbench;
   `define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
      $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
   logic        core_clk, reset, link_clk, link_data, irq, wake, vector_branch, baud_tick, ie;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] vector_addr;
   logic [7:0]  ri [5] = '{`IDX_TX_STATUS, `IDX_BAUD_DIV, `IDX_IRQ_ENABLES, `IDX_RX_DATA, `IDX_IRQ_FLAGS};
   logic [7:0]  rv [5] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
   int          num_errors, check_count;

   usart_sync_slave_receive u_dut (
      .core_clk(core_clk), .reset(reset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_clk(link_clk),
      .link_data(link_data), .irq(irq), .wake(wake), .vector_branch(vector_branch),
      .vector_addr(vector_addr), .baud_tick(baud_tick)
   );
   link_master u_master (.link_clk(link_clk), .link_data(link_data));

   // 10 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Buffer returns only the low eight bits of a word
   function automatic logic [31:0] exp_rx(input logic [8:0] w);
      return {24'h0, w[7:0]};
   endfunction

   // Prescale of 16 with high-speed select cleared, then divisor plus one
   function automatic int exp_period(input logic [7:0] dv);
      return 16 * (dv + 1);
   endfunction

   // Write one register word; address and data offered together
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
      int n;
      @(posedge core_clk);
      n = 0;
      s_axi_awaddr  <= {22'h0, idx, 2'b00};
      s_axi_wdata   <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
   endtask

   // Read one register word into d and r
   task automatic rd_reg(input logic [7:0] idx);
      int n;
      @(posedge core_clk);
      n = 0;
      s_axi_araddr  <= {22'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Poll the flag register, bounded, until a word has landed
   task automatic wait_flag();
      int n;
      n = 0;
      do begin
         rd_reg(`IDX_IRQ_FLAGS);
         n++;
      end while (d[`RCV_IRQ_BIT] !== 1'b1 && n < 60);
   endtask

   // Send a word and check flag, interrupt, ninth bit, data and clear-on-read
   task automatic recv(input logic [8:0] w, input logic nine);
      u_master.send_word(w, nine ? 9 : 8);
      wait_flag();
      `CHK("flag", 1'b1, d[`RCV_IRQ_BIT])
      `CHK("irq", ie, irq)
      rd_reg(`IDX_RX_STATUS);
      `CHK("ninth", nine & w[8], d[`NINTH_DATA_BIT])
      rd_reg(`IDX_RX_DATA);
      `CHK("data", exp_rx(w), d)
      rd_reg(`IDX_IRQ_FLAGS);
      `CHK("irq off", 1'b0, irq)
   endtask

   // Measure the spacing of two divider ticks
   task automatic baud_period(input logic [7:0] dv);
      int n;
      wr_reg(`IDX_BAUD_DIV, dv);
      n = 0;
      do @(posedge core_clk); while (baud_tick !== 1'b1 && ++n < 5000);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (baud_tick !== 1'b1 && n < 5000);
      `CHK("baud period", exp_period(dv), n)
   endtask

   task automatic end_sim();
      if (num_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog sized well above the baud and link traffic of the run
   initial begin
      repeat (30000) @(posedge core_clk);
      num_errors++;
      end_sim();
   end

   // Main sequence
   initial begin
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      reset       = 1'b1;
      ie          = 1'b0;
      num_errors  = 0;
      check_count = 0;
      void'($urandom(32'h91EA));
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      // Reset values and an unmapped read
      for (int i = 0; i < 5; i++) begin
         rd_reg(ri[i]);
         `CHK("reset value", {24'h0, rv[i]}, d)
      end
      rd_reg(8'h40);
      `CHK("unmapped resp", 2'b10, r)
      `CHK("unmapped data", 32'h0, d)
      // Slave setup: sync on, external clock, receive interrupt enabled
      wr_reg(`IDX_TX_STATUS, 8'h10);
      wr_reg(`IDX_IRQ_ENABLES, 8'h20);
      ie = 1'b1;
      // Eight-bit words, corners then random; single-receive bit must not matter
      for (int i = 0; i < 6; i++) begin
         wr_reg(`IDX_RX_STATUS, i[0] ? 8'hB0 : 8'h90);
         recv(i == 0 ? 9'h000 : i == 1 ? 9'h0FF : 9'($urandom), 1'b0);
      end
      // Nine-bit words with both values of the ninth bit
      wr_reg(`IDX_RX_STATUS, 8'hD0);
      for (int i = 0; i < 4; i++) recv({i[0], 8'($urandom)}, 1'b1);
      // Interrupt masked: flag still sets, no interrupt
      wr_reg(`IDX_RX_STATUS, 8'h90);
      wr_reg(`IDX_IRQ_ENABLES, 8'h00);
      ie = 1'b0;
      recv(9'($urandom), 1'b0);
      // Second word while the flag stands gives overrun; cleared by dropping receive
      u_master.send_word(9'h0A5, 8);
      wait_flag();
      u_master.send_word(9'h05A, 8);
      repeat (20) @(posedge core_clk);
      rd_reg(`IDX_RX_STATUS);
      `CHK("overrun", 1'b1, d[`OVERRUN_BIT])
      wr_reg(`IDX_RX_STATUS, 8'h80);
      rd_reg(`IDX_RX_STATUS);
      `CHK("overrun clr", 1'b0, d[`OVERRUN_BIT])
      wr_reg(`IDX_IRQ_FLAGS, 8'h20);
      rd_reg(`IDX_IRQ_FLAGS);
      `CHK("flag w1c", 1'b0, d[`RCV_IRQ_BIT])
      // Word received in sleep wakes the chip and branches to the vector
      wr_reg(`IDX_RX_STATUS, 8'h90);
      wr_reg(`IDX_IRQ_ENABLES, 8'h20);
      wr_reg(`IDX_SLEEP_CTRL, 8'h01);
      wr_reg(`IDX_CPU_CTRL, 8'h01);
      u_master.send_word(9'h03C, 8);
      // Wake stands a single cycle, so look mid-cycle where it is settled
      for (int n = 0; n < 200 && wake !== 1'b1; n++) @(negedge core_clk);
      `CHK("wake", 1'b1, wake)
      `CHK("branch", 1'b1, vector_branch)
      `CHK("vector", 16'h0004, vector_addr)
      rd_reg(`IDX_RX_DATA);
      `CHK("sleep data", exp_rx(9'h03C), d)
      rd_reg(`IDX_IRQ_FLAGS);
      `CHK("wake off", 1'b0, wake)
      wr_reg(`IDX_SLEEP_CTRL, 8'h00);
      // Divider: fastest and slowest settings
      baud_period(8'h00);
      baud_period(8'hFF);
      end_sim();
   end
endmodule
